// [common/prog_space_pkg.sv]
// constants for the program space and vector unit
package prog_space_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 31;
  localparam int FLASH_KB_DEFAULT = 128;
  localparam logic [20:0] RESET_VEC = 21'h000000;
  localparam logic [20:0] HIGH_VEC = 21'h000008;
  localparam logic [20:0] LOW_VEC = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [4:0] SP_RESET = 5'h00;
  localparam logic [4:0] SP_MAX = 5'h1F;
  localparam logic [15:0] NOP_WORD = 16'h0000;
endpackage

// [hw/program_space_vector_unit.sv]
// program counter, hard vectors, return stack push and program fetch bus
module program_space_vector_unit #(
  parameter int FLASH_KB = prog_space_pkg::FLASH_KB_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // sequencing requests from the core
  input wire logic fetch_advance,
  input wire logic pc_load,
  input wire logic [20:0] pc_load_value,
  input wire logic int_ack,
  input wire logic wake_up,
  input wire logic int_pending_high,
  input wire logic int_pending_low,
  input wire logic global_int_enable_high,
  input wire logic global_int_enable_low,
  input wire logic [7:0] interrupt_control_regs,
  input wire logic [7:0] peripheral_int_flag_regs,
  // program memory bus
  input wire logic [15:0] flash_rdata,
  output logic [20:0] prog_addr,
  output logic [15:0] instr_word,
  output logic [20:0] program_counter,
  output logic [7:0] prog_counter_low_byte,
  // return stack top, stack pointer and wake-up status
  output logic [7:0] stack_top_upper,
  output logic [7:0] stack_top_high,
  output logic [7:0] stack_top_low,
  output logic [4:0] return_stack_pointer,
  output logic wake_vectored,
  output logic wake_flag_missing
);

  // ****************************************
  // configuration check
  // ****************************************
  localparam logic [20:0] FLASH_TOP = 21'(FLASH_KB * 1024);

  if (FLASH_KB != 32 && FLASH_KB != 64 && FLASH_KB != 128) begin
    $error("flash size must be 32, 64 or 128 Kbytes");
  end

  // ****************************************
  // vector selection
  // ****************************************
  function automatic logic [20:0] pick_vector(input logic hi);
    return hi ? prog_space_pkg::HIGH_VEC : prog_space_pkg::LOW_VEC;
  endfunction

  logic [20:0] pc_q, pc_d;
  logic [4:0] sp_q;
  logic [20:0] tos_q;
  logic [20:0] addr_q;
  logic [15:0] word_q;
  logic vect_q, miss_q;
  logic [20:0] stack_mem [1:prog_space_pkg::STACK_DEPTH];
  logic gie, wake_int, take_int, any_int, push_ok;

  assign gie = global_int_enable_high | global_int_enable_low;
  assign any_int = int_pending_high | int_pending_low;
  assign wake_int = wake_up & any_int & gie;
  assign take_int = wake_int | (int_ack & any_int);
  assign push_ok = sp_q != prog_space_pkg::SP_MAX;

  always_comb begin
    pc_d = pc_q;
    if (take_int) begin
      pc_d = pick_vector(int_pending_high);
    end else if (pc_load) begin
      pc_d = pc_load_value;
    end else if (fetch_advance) begin
      pc_d = pc_q + prog_space_pkg::PC_STEP;
    end
    pc_d[0] = 1'b0;
  end

  // ****************************************
  // program counter
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pc_q <= prog_space_pkg::RESET_VEC;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ****************************************
  // return stack push
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sp_q <= prog_space_pkg::SP_RESET;
      tos_q <= prog_space_pkg::RESET_VEC;
    end else if (take_int && push_ok) begin
      sp_q <= sp_q + 5'h01;
      tos_q <= pc_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!sys_rst && take_int && push_ok) begin
      stack_mem[sp_q + 5'h01] <= pc_q;
    end
  end

  // ****************************************
  // program fetch bus
  // ****************************************
  always_ff @(posedge clock) begin
    // own fetch bus, zero above flash
    if (sys_rst) begin
      addr_q <= prog_space_pkg::RESET_VEC;
      word_q <= prog_space_pkg::NOP_WORD;
    end else begin
      addr_q <= pc_d;
      word_q <= (pc_q < FLASH_TOP) ? flash_rdata : prog_space_pkg::NOP_WORD;
    end
  end

  // ****************************************
  // wake-up status
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vect_q <= 1'b0;
      miss_q <= 1'b0;
    end else begin
      vect_q <= wake_int;
      miss_q <= wake_int && interrupt_control_regs == 8'h00 &&
                peripheral_int_flag_regs == 8'h00;
    end
  end

  assign program_counter = pc_q;
  assign prog_counter_low_byte = pc_q[7:0];
  assign prog_addr = addr_q;
  assign instr_word = word_q;
  assign stack_top_upper = {3'h0, tos_q[20:16]};
  assign stack_top_high = tos_q[15:8];
  assign stack_top_low = tos_q[7:0];
  assign return_stack_pointer = sp_q;
  assign wake_vectored = vect_q;
  assign wake_flag_missing = miss_q;

  // ****************************************
  // checks
  // ****************************************
  sequence s_wake;
    wake_up && any_int && gie && push_ok;
  endsequence

  property p_tos_load;
    @(posedge clock) disable iff (sys_rst)
      s_wake |=> {stack_top_upper[4:0], stack_top_high, stack_top_low}
        == $past(pc_q);
  endproperty
  a_tos_load: assert property (p_tos_load) else $error("tos not pc");

  property p_sp_inc;
    @(posedge clock) disable iff (sys_rst)
      s_wake |=> return_stack_pointer == $past(sp_q) + 5'h01;
  endproperty
  a_sp_inc: assert property (p_sp_inc) else $error("sp not advanced");

  property p_wake_vec;
    @(posedge clock) disable iff (sys_rst)
      (wake_int && int_pending_high) |=> pc_q == prog_space_pkg::HIGH_VEC;
  endproperty
  a_wake_vec: assert property (p_wake_vec) else $error("bad vector");

  property p_low_vec;
    @(posedge clock) disable iff (sys_rst)
      (take_int && !int_pending_high) |=> pc_q == prog_space_pkg::LOW_VEC;
  endproperty
  a_low_vec: assert property (p_low_vec) else $error("bad low vec");

  property p_ack_vec;
    @(posedge clock) disable iff (sys_rst)
      (int_ack && int_pending_high && int_pending_low) |=>
        pc_q == prog_space_pkg::HIGH_VEC;
  endproperty
  a_ack_vec: assert property (p_ack_vec) else $error("no precedence");

  property p_zero_fill;
    @(posedge clock) disable iff (sys_rst)
      (pc_q >= FLASH_TOP) |=> instr_word == prog_space_pkg::NOP_WORD;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("not nop");

  property p_step;
    @(posedge clock) disable iff (sys_rst)
      (fetch_advance && !pc_load && !take_int) |=>
        pc_q == (($past(pc_q) + prog_space_pkg::PC_STEP) & 21'h1FFFFE);
  endproperty
  a_step: assert property (p_step) else $error("pc step wrong");

  property p_reset;
    @(posedge clock) sys_rst |=> pc_q == prog_space_pkg::RESET_VEC &&
      return_stack_pointer == prog_space_pkg::SP_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset vector");

  property p_fetch_addr;
    @(posedge clock) disable iff (sys_rst)
      1'b1 |=> prog_addr == pc_q;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("addr");

endmodule

// [dv/flash_model.sv]
// program flash stand-in feeding the fetch bus
module flash_model #(
  parameter int FLASH_KB = 32
) (
  // fetch bus
  input wire logic [20:0] prog_addr,
  output logic [15:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    flash_rdata = {prog_addr[16:2], 1'b1};
    if (prog_addr >= 21'(FLASH_KB * 1024)) flash_rdata = ~flash_rdata;
  end
endmodule

// [dv/program_space_vector_unit_tb.sv]
// self-checking bench for the program space and vector unit
module program_space_vector_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, sys_rst = 1, fetch_advance = 0, pc_load = 0;
  logic int_ack = 0, wake_up = 0, int_pending_high = 0;
  logic int_pending_low = 0, global_int_enable_high = 0;
  logic global_int_enable_low = 0;
  logic [20:0] pc_load_value = '0;
  logic [7:0] interrupt_control_regs = '0, peripheral_int_flag_regs = '0;
  logic [15:0] flash_rdata, instr_word;
  logic [20:0] prog_addr, program_counter;
  logic [7:0] prog_counter_low_byte, stack_top_upper, stack_top_high;
  logic [7:0] stack_top_low;
  logic [4:0] return_stack_pointer;
  logic wake_vectored, wake_flag_missing;
  int mismatches = 0, compares = 0;
  always #25 clock = ~clock;
  program_space_vector_unit #(.FLASH_KB(32)) dut (.clock(clock),
    .sys_rst(sys_rst), .fetch_advance(fetch_advance), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .int_ack(int_ack), .wake_up(wake_up),
    .int_pending_high(int_pending_high), .int_pending_low(int_pending_low),
    .global_int_enable_high(global_int_enable_high),
    .global_int_enable_low(global_int_enable_low),
    .interrupt_control_regs(interrupt_control_regs),
    .peripheral_int_flag_regs(peripheral_int_flag_regs),
    .flash_rdata(flash_rdata), .prog_addr(prog_addr),
    .instr_word(instr_word), .program_counter(program_counter),
    .prog_counter_low_byte(prog_counter_low_byte),
    .stack_top_upper(stack_top_upper), .stack_top_high(stack_top_high),
    .stack_top_low(stack_top_low),
    .return_stack_pointer(return_stack_pointer),
    .wake_vectored(wake_vectored), .wake_flag_missing(wake_flag_missing));
  flash_model #(.FLASH_KB(32)) flash (.prog_addr(prog_addr),
    .flash_rdata(flash_rdata));
  task automatic chk(input string name, input logic [20:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic go();
    @(posedge clock);
    {fetch_advance, pc_load, int_ack, wake_up} <= 4'h0;
    {int_pending_high, int_pending_low} <= 2'h0;
    {global_int_enable_high, global_int_enable_low} <= 2'h0;
    #1;
  endtask
  task automatic load(input logic [20:0] v, adv);
    @(posedge clock);
    pc_load <= !adv[0];
    fetch_advance <= adv[0];
    pc_load_value <= v;
    go();
  endtask
  task automatic irq(input logic ack, wk, ph, pl, gh, gl,
      input logic [7:0] ic, pf);
    @(posedge clock);
    {int_ack, wake_up, int_pending_high, int_pending_low} <= {ack, wk, ph, pl};
    {global_int_enable_high, global_int_enable_low} <= {gh, gl};
    interrupt_control_regs <= ic;
    peripheral_int_flag_regs <= pf;
    go();
  endtask
  task automatic state(input logic [20:0] pc, tos, input logic [4:0] sp);
    chk("pc", pc, program_counter);
    chk("sp", 21'(sp), 21'(return_stack_pointer));
    chk("tos", tos, {stack_top_upper[4:0], stack_top_high, stack_top_low});
  endtask
  task automatic s_fetch();
    load(21'h007FFD, 0);
    chk("pc odd", 21'h007FFC, program_counter);
    chk("addr", 21'h007FFC, prog_addr);
    go();
    chk("word", 21'h3FFF, 21'(instr_word));
    load(0, 1);
    chk("pc step", 21'h007FFE, program_counter);
    load(0, 1);
    go();
    chk("word top", 0, 21'(instr_word));
    load(21'h1FFFFE, 0);
    go();
    chk("pc wide", 21'h1FFFFE, program_counter);
    chk("addr wide", 21'h1FFFFE, prog_addr);
    chk("word far", 0, 21'(instr_word));
  endtask
  task automatic s_irq();
    load(21'h000100, 0);
    irq(0, 1, 1, 0, 1, 0, 8'h01, 8'h00);
    state(21'h000008, 21'h000100, 5'h01);
    chk("vectored", 1, 21'(wake_vectored));
    chk("flag ok", 0, 21'(wake_flag_missing));
    irq(0, 1, 0, 1, 0, 1, 8'h00, 8'h04);
    state(21'h000018, 21'h000008, 5'h02);
    chk("vectored", 1, 21'(wake_vectored));
    irq(0, 1, 1, 1, 0, 0, 8'h01, 8'h00);
    state(21'h000018, 21'h000008, 5'h02);
    chk("no gie", 0, 21'(wake_vectored));
    irq(1, 0, 1, 1, 0, 0, 8'h00, 8'h00);
    state(21'h000008, 21'h000018, 5'h03);
    chk("low byte", 21'h08, 21'(prog_counter_low_byte));
    irq(1, 0, 0, 1, 0, 0, 8'h00, 8'h00);
    state(21'h000018, 21'h000008, 5'h04);
    irq(0, 1, 1, 0, 1, 0, 8'h00, 8'h00);
    chk("no flag", 1, 21'(wake_flag_missing));
  endtask
  task automatic s_reset();
    @(posedge clock);
    sys_rst <= 1;
    @(posedge clock);
    sys_rst <= 0;
    #1;
    state(0, 0, 5'h00);
    chk("rst addr", 0, prog_addr);
    chk("rst word", 0, 21'(instr_word));
    chk("rst vect", 0, 21'(wake_vectored));
    chk("rst miss", 0, 21'(wake_flag_missing));
  endtask
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    #1;
    state(0, 0, 5'h00);
    s_fetch();
    s_irq();
    s_reset();
    print_verdict();
  end
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule
